// ===== logic/mst_top.sv
// Route table block: slave address lookup, TCP index lookup, auto-scan
// and peer global data placement, with an Avalon-MM register slave.
// Assumes requests and peer data arrive synchronous to i_clk.
`timescale 1ns/10ps
module mst_top
  import mst_pkg::*;
#(
  parameter int SCAN_ENTRIES = 48,
  parameter int NODES        = 64
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  output logic [31:0]             o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // Incoming requests
  input  wire logic               i_sreq_valid,
  input  wire logic               i_sreq_port,
  input  wire logic [7:0]         i_sreq_addr,
  input  wire logic               i_treq_valid,
  input  wire logic [7:0]         i_treq_index,
  output logic                    o_req_ready,
  // Forwarded request
  output logic                    o_fwd_valid,
  input  wire logic               i_fwd_ready,
  output logic [1:0]              o_fwd_src,
  output logic                    o_fwd_local,
  output logic [LEN_W-1:0]        o_fwd_len,
  output logic [ROUTE_W-1:0]      o_fwd_route,
  output logic [7:0]              o_fwd_ret_drop,
  output logic                    o_discard,
  // Auto-scan transfers
  output logic                    o_scan_valid,
  input  wire logic               i_scan_ready,
  output logic                    o_scan_port,
  output logic                    o_scan_dir,
  output logic [11:0]             o_scan_local,
  output logic [13:0]             o_scan_remote,
  output logic [7:0]              o_scan_count,
  output logic [LEN_W-1:0]        o_scan_len,
  output logic [ROUTE_W-1:0]      o_scan_route,
  // Peer global data in, mailbox write out
  input  wire logic               i_gd_valid,
  input  wire logic [5:0]         i_gd_node,
  input  wire logic [4:0]         i_gd_word,
  input  wire logic [15:0]        i_gd_data,
  output logic                    o_mbx_wr,
  output logic [11:0]             o_mbx_addr,
  output logic [15:0]             o_mbx_data
);
  // ==========================================================
  // Register bus
  logic        req_bus;
  logic        acc;
  logic [31:0] rd_mux;
  logic [2:0]  ctrl_q;
  logic [7:0]  start_q [2];
  logic [7:0]  eth_drop_q;
  logic [31:0] stage_lo_q;
  logic [31:0] stage_hi_q;
  logic [31:0] scan_a_q;
  logic [31:0] scan_b_q;
  logic [15:0] disc_cnt_q;
  logic [15:0] fwd_cnt_q;
  mst_state_t  st_q;

  assign req_bus = i_avs_read || i_avs_write;
  assign acc     = req_bus && !o_avs_waitrequest;

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      REG_CTRL:     rd_mux = {29'h0, ctrl_q};
      REG_START0:   rd_mux = {24'h0, start_q[0]};
      REG_START1:   rd_mux = {24'h0, start_q[1]};
      REG_ETH_DROP: rd_mux = {24'h0, eth_drop_q};
      REG_STAGE_LO: rd_mux = stage_lo_q;
      REG_STAGE_HI: rd_mux = stage_hi_q;
      REG_SCAN_A:   rd_mux = scan_a_q;
      REG_SCAN_B:   rd_mux = scan_b_q;
      REG_STATUS:   rd_mux = {fwd_cnt_q, disc_cnt_q};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access, then accept
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= !(req_bus && o_avs_waitrequest);
      if (req_bus && o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q     <= 3'h0;
      start_q[0] <= START_RST;
      start_q[1] <= START_RST;
      eth_drop_q <= 8'h00;
      stage_lo_q <= 32'h0000_0000;
      stage_hi_q <= 32'h0000_0000;
      scan_a_q   <= 32'h0000_0000;
      scan_b_q   <= 32'h0000_0000;
    end else if (acc && i_avs_write) begin
      case (i_avs_address)
        REG_CTRL:     ctrl_q <= i_avs_writedata[2:0];
        REG_START0:   start_q[0] <= i_avs_writedata[7:0];
        REG_START1:   start_q[1] <= i_avs_writedata[7:0];
        REG_ETH_DROP: eth_drop_q <= i_avs_writedata[7:0];
        REG_STAGE_LO: stage_lo_q <= i_avs_writedata;
        REG_STAGE_HI: stage_hi_q <= i_avs_writedata;
        REG_SCAN_A:   scan_a_q <= i_avs_writedata;
        REG_SCAN_B:   scan_b_q <= i_avs_writedata;
        default:      ;
      endcase
    end
  end

  // ==========================================================
  // Route table: serial port 0, serial port 1, then Ethernet
  logic                    rt_we;
  logic [8:0]              rt_waddr;
  logic [8:0]              idx_q;
  logic [ROUTE_W+LEN_W-1:0] rt_rd;
  logic [LEN_W-1:0]        rt_len;
  logic [1:0]              src_q;
  logic                    miss_q;
  logic                    take;
  logic                    is_ser;
  logic [8:0]              off;
  logic                    in_win;

  assign rt_we    = acc && i_avs_write && i_avs_address == REG_ROUTE_WR;
  assign rt_waddr = i_avs_writedata[8:0];
  assign rt_len   = rt_rd[ROUTE_W+LEN_W-1:ROUTE_W];

  mst_ram #(.W(ROUTE_W + LEN_W), .AW(9)) u_route (
    .i_clk   (i_clk),
    .i_we    (rt_we),
    .i_waddr (rt_waddr),
    .i_wdata ({i_avs_writedata[LEN_POS+LEN_W-1:LEN_POS],
               stage_hi_q, stage_lo_q}),
    .i_raddr (idx_q),
    .o_rdata (rt_rd)
  );

  // Serial window check, serial wins over TCP when both wait
  assign take   = o_req_ready && (i_sreq_valid || i_treq_valid);
  assign is_ser = i_sreq_valid;
  assign off    = {1'b0, i_sreq_addr} - {1'b0, start_q[i_sreq_port]};
  assign in_win = i_sreq_addr >= start_q[i_sreq_port]
    && off < 9'(SLAVE_SPAN);

  // Lookup sequencer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q        <= ST_IDLE;
      o_req_ready <= 1'b1;
      idx_q       <= 9'h000;
      src_q       <= SRC_SER0;
      miss_q      <= 1'b0;
      o_fwd_valid <= 1'b0;
      o_discard   <= 1'b0;
    end else begin
      o_discard <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (take) begin
            o_req_ready <= 1'b0;
            st_q        <= ST_READ;
            if (is_ser) begin
              src_q  <= {1'b0, i_sreq_port};
              idx_q  <= {1'b0, i_sreq_port, off[6:0]};
              miss_q <= !in_win || !ctrl_q[i_sreq_port];
            end else begin
              src_q  <= SRC_ETH;
              idx_q  <= {1'b1, i_treq_index};
              miss_q <= 1'b0;
            end
          end
        end
        ST_READ: st_q <= ST_EVAL;
        ST_EVAL: begin
          if (src_q != SRC_ETH && (miss_q || rt_len == 4'h0)) begin
            o_discard   <= 1'b1;
            o_req_ready <= 1'b1;
            st_q        <= ST_IDLE;
          end else begin
            o_fwd_valid <= 1'b1;
            st_q        <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (i_fwd_ready) begin
            o_fwd_valid <= 1'b0;
            o_req_ready <= 1'b1;
            st_q        <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Forward payload; TCP gets own drop as return path
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_fwd_src      <= SRC_SER0;
      o_fwd_local    <= 1'b0;
      o_fwd_len      <= 4'h0;
      o_fwd_route    <= '0;
      o_fwd_ret_drop <= 8'h00;
    end else if (st_q == ST_EVAL) begin
      o_fwd_src      <= src_q;
      o_fwd_local    <= src_q == SRC_ETH && rt_len == 4'h0;
      o_fwd_len      <= rt_len;
      o_fwd_route    <= rt_rd[ROUTE_W-1:0];
      o_fwd_ret_drop <= (src_q == SRC_ETH) ? eth_drop_q
                        : rt_rd[7:0];
    end
  end

  // Status counters
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      disc_cnt_q <= 16'h0000;
      fwd_cnt_q  <= 16'h0000;
    end else begin
      if (o_discard) begin
        disc_cnt_q <= disc_cnt_q + 16'h0001;
      end
      if (o_fwd_valid && i_fwd_ready) begin
        fwd_cnt_q <= fwd_cnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Peer global data placement
  logic [5:0]  gd_cnt_q   [NODES];
  logic [11:0] gd_start_q [NODES];
  logic [12:0] gd_sum;

  assign gd_sum = {1'b0, gd_start_q[i_gd_node]} + {8'h00, i_gd_word};

  // Node configuration table
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int n = 0; n < NODES; n++) begin
        gd_cnt_q[n]   <= 6'h00;
        gd_start_q[n] <= 12'h000;
      end
    end else if (acc && i_avs_write && i_avs_address == REG_GD_CFG) begin
      gd_cnt_q[i_avs_writedata[5:0]] <=
        i_avs_writedata[GD_CNT_POS+5:GD_CNT_POS];
      gd_start_q[i_avs_writedata[5:0]] <=
        i_avs_writedata[GD_START_POS+11:GD_START_POS];
    end
  end

  // Words beyond the node count or the mailbox end are dropped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_mbx_wr   <= 1'b0;
      o_mbx_addr <= 12'h000;
      o_mbx_data <= 16'h0000;
    end else begin
      o_mbx_wr <= i_gd_valid && {1'b0, i_gd_word} < gd_cnt_q[i_gd_node]
        && gd_sum < 13'(MBX_REGS);
      o_mbx_addr <= gd_sum[11:0];
      o_mbx_data <= i_gd_data;
    end
  end

  // ==========================================================
  // Auto-scan
  mst_scan #(.ENTRIES(SCAN_ENTRIES)) u_scan (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_en      (ctrl_q[CTRL_SCAN]),
    .i_we      (acc && i_avs_write && i_avs_address == REG_SCAN_WR),
    .i_waddr   ({i_avs_writedata[PORT_POS], i_avs_writedata[5:0]}),
    .i_wdata   ({stage_hi_q, stage_lo_q,
                 scan_b_q[SCAN_LEN_POS+LEN_W-1:SCAN_LEN_POS],
                 scan_b_q[DIR_POS], scan_b_q[7:0],
                 scan_a_q[REMOTE_POS+13:REMOTE_POS],
                 scan_a_q[11:0]}),
    .o_valid   (o_scan_valid),
    .i_ready   (i_scan_ready),
    .o_port    (o_scan_port),
    .o_dir     (o_scan_dir),
    .o_local   (o_scan_local),
    .o_remote  (o_scan_remote),
    .o_count   (o_scan_count),
    .o_len     (o_scan_len),
    .o_route   (o_scan_route)
  );

  // ==========================================================
  // Checks
  a_slave_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && is_ser && !ctrl_q[i_sreq_port] |-> ##3 o_discard && !o_fwd_valid)
    else $error("disabled slave port did not discard");
  a_slave_index: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && is_ser |=> idx_q[6:0] == 7'($past(i_sreq_addr)
      - start_q[src_q[0]]) && idx_q[8] == 1'b0)
    else $error("serial lookup index wrong");
  a_route_carry: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_q == ST_EVAL && rt_len != 4'h0 && !miss_q |=> o_fwd_valid
      && o_fwd_route == $past(rt_rd[ROUTE_W-1:0]))
    else $error("stored route not forwarded");
  a_empty_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_q == ST_EVAL && src_q != SRC_ETH && rt_len == 4'h0
      |=> o_discard && !o_fwd_valid ##1 o_req_ready)
    else $error("empty serial entry not discarded");
  a_window_out: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && is_ser && i_sreq_addr < start_q[i_sreq_port] |-> ##3 o_discard)
    else $error("address below window not discarded");
  a_tcp_index: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && !is_ser |=> idx_q == {1'b1, $past(i_treq_index)})
    else $error("tcp index lookup wrong");
  a_tcp_local: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_q == ST_EVAL && src_q == SRC_ETH && rt_len == 4'h0
      |=> o_fwd_valid && o_fwd_local && !o_discard)
    else $error("empty tcp entry not run locally");
  a_ret_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_fwd_valid && o_fwd_src == SRC_ETH |-> o_fwd_ret_drop == eth_drop_q)
    else $error("tcp return drop not own drop");
  a_gd_place: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_gd_valid && {1'b0, i_gd_word} >= gd_cnt_q[i_gd_node] |=> !o_mbx_wr)
    else $error("global data beyond node count stored");
  c_ser_fwd: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_fwd_valid && i_fwd_ready && o_fwd_src != SRC_ETH);
  c_tcp_local: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_fwd_valid && o_fwd_local);
  c_discard: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_discard);
  c_gd_write: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_mbx_wr);
endmodule

// ===== logic/mst_pkg.sv
// Shared constants for the slave route table block.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package mst_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_START0   = 8'h04;
  localparam logic [7:0] REG_START1   = 8'h08;
  localparam logic [7:0] REG_ETH_DROP = 8'h0c;
  localparam logic [7:0] REG_STAGE_LO = 8'h10;
  localparam logic [7:0] REG_STAGE_HI = 8'h14;
  localparam logic [7:0] REG_ROUTE_WR = 8'h18;
  localparam logic [7:0] REG_SCAN_A   = 8'h1c;
  localparam logic [7:0] REG_SCAN_B   = 8'h20;
  localparam logic [7:0] REG_SCAN_WR  = 8'h24;
  localparam logic [7:0] REG_GD_CFG   = 8'h28;
  localparam logic [7:0] REG_STATUS   = 8'h2c;
  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_SLV0    = 0;
  localparam int CTRL_SLV1    = 1;
  localparam int CTRL_SCAN    = 2;
  localparam int LEN_POS      = 16;
  localparam int REMOTE_POS   = 16;
  localparam int DIR_POS      = 8;
  localparam int SCAN_LEN_POS = 12;
  localparam int PORT_POS     = 8;
  localparam int GD_CNT_POS   = 8;
  localparam int GD_START_POS = 16;
  localparam logic [7:0] START_RST = 8'h01;
  // ==========================================================
  // Table sizes and limits
  localparam int ROUTE_W     = 64;
  localparam int LEN_W       = 4;
  localparam int SLAVE_SPAN  = 128;
  localparam int ETH_ENTRIES = 256;
  localparam int MBX_REGS    = 2048;
  localparam int REMOTE_MAX  = 8192;
  localparam int COUNT_MAX   = 128;
  localparam int GD_MAX      = 32;
  // Request sources
  localparam logic [1:0] SRC_SER0 = 2'h0;
  localparam logic [1:0] SRC_SER1 = 2'h1;
  localparam logic [1:0] SRC_ETH  = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EVAL, ST_OUT} mst_state_t;
endpackage

// ===== logic/mst_ram.sv
// Simple dual-port table memory with registered read data.
// Assumes one synchronous clock; contents are undefined after reset.
`timescale 1ns/10ps
module mst_ram #(
  parameter int W  = 68,
  parameter int AW = 9
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// ===== logic/mst_scan.sv
// Auto-scan stepper: walks the per-port transfer tables in order.
// Assumes the consumer of o_valid accepts with i_ready.
`timescale 1ns/10ps
module mst_scan
  import mst_pkg::*;
#(
  parameter int ENTRIES = 48
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  // Control and table write
  input  wire logic               i_en,
  input  wire logic               i_we,
  input  wire logic [6:0]         i_waddr,
  input  wire logic [102:0]       i_wdata,
  // Transfer out
  output logic                    o_valid,
  input  wire logic               i_ready,
  output logic                    o_port,
  output logic                    o_dir,
  output logic [11:0]             o_local,
  output logic [13:0]             o_remote,
  output logic [7:0]              o_count,
  output logic [LEN_W-1:0]        o_len,
  output logic [ROUTE_W-1:0]      o_route
);
  logic [5:0]   ent_q;
  logic         port_q;
  logic [102:0] rd;
  logic         live;
  mst_state_t   st_q;

  mst_ram #(.W(103), .AW(7)) u_tab (
    .i_clk   (i_clk),
    .i_we    (i_we),
    .i_waddr (i_waddr),
    .i_wdata (i_wdata),
    .i_raddr ({port_q, ent_q}),
    .o_rdata (rd)
  );

  // Entry usable only with nonzero, in-range local, remote and count
  assign live = i_en && rd[11:0] != 12'h000 && rd[11:0] <= 12'(MBX_REGS)
    && rd[25:12] != 14'h0000 && rd[25:12] <= 14'(REMOTE_MAX)
    && rd[33:26] != 8'h00 && rd[33:26] <= 8'(COUNT_MAX);

  // Table walk, wrapping over both ports
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q    <= ST_READ;
      ent_q   <= 6'h00;
      port_q  <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      case (st_q)
        ST_READ: st_q <= ST_EVAL;
        ST_EVAL: begin
          if (live) begin
            o_valid <= 1'b1;
            st_q    <= ST_OUT;
          end else begin
            st_q <= ST_READ;
          end
        end
        ST_OUT: begin
          if (i_ready) begin
            o_valid <= 1'b0;
            st_q    <= ST_READ;
          end
        end
        default: st_q <= ST_READ;
      endcase
      if ((st_q == ST_EVAL && !live) || (st_q == ST_OUT && i_ready)) begin
        if (ent_q == 6'(ENTRIES - 1)) begin
          ent_q  <= 6'h00;
          port_q <= ~port_q;
        end else begin
          ent_q <= ent_q + 6'h01;
        end
      end
    end
  end

  // Transfer fields captured from the entry
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      {o_port, o_dir, o_local, o_remote, o_count} <= '0;
      {o_len, o_route} <= '0;
    end else if (st_q == ST_EVAL && live) begin
      o_port   <= port_q;
      o_local  <= rd[11:0];
      o_remote <= rd[25:12];
      o_count  <= rd[33:26];
      o_dir    <= rd[34];
      o_len    <= rd[34+LEN_W:35];
      o_route  <= rd[102:35+LEN_W];
    end
  end

  a_scan_live: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_valid |-> o_local != 0 && o_remote != 0 && o_count != 0)
    else $error("scan issued a disabled entry");
  a_scan_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_valid && !i_ready |=> o_valid && $stable(o_local))
    else $error("scan transfer dropped before accept");
  c_scan_wrap: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_valid && i_ready && o_port);
endmodule

// ===== tb/mst_req_model.sv
// Request source model: a Modbus master and a TCP client.
// Assumes the bench pulses i_go for one cycle while o_busy is low.
`timescale 1ns/10ps
module mst_req_model (
  // Clock, command and handshake
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic       i_tcp,
  input  wire logic       i_port,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_ready,
  output logic            o_busy = 1'b0,
  // Request lines
  output logic            o_sreq_valid = 1'b0,
  output logic            o_sreq_port = 1'b0,
  output logic [7:0]      o_sreq_addr = 8'h00,
  output logic            o_treq_valid = 1'b0,
  output logic [7:0]      o_treq_index = 8'h00
);
  // Hold a request until taken; released lines flip so stale values fail
  always @(posedge i_clk) begin
    if (i_go) begin
      o_busy <= 1'b1;
      o_sreq_valid <= !i_tcp;
      o_treq_valid <= i_tcp;
      o_sreq_port <= i_port;
      o_sreq_addr <= i_addr;
      o_treq_index <= i_addr;
    end else if (o_busy && i_ready) begin
      o_busy <= 1'b0;
      o_sreq_valid <= 1'b0;
      o_treq_valid <= 1'b0;
      o_sreq_addr <= ~o_sreq_addr;
      o_treq_index <= ~o_treq_index;
    end
  end
endmodule

// ===== tb/modbus_slave_route_table_bench.sv
// Bench for the route table block: lookups, scan and global data.
// Assumes the register map and latencies of the block's package.
`timescale 1ns/10ps
module modbus_slave_route_table_bench import mst_pkg::*;;
  // ==========================================================
  // Signals
  logic i_clk = 0, i_sys_rst = 1, i_avs_read = 0, i_avs_write = 0;
  logic [7:0] i_avs_address = 0, i_sreq_addr, i_treq_index, adr = 0;
  logic [31:0] i_avs_writedata = 0, o_avs_readdata;
  logic o_avs_waitrequest, i_sreq_valid, i_sreq_port, i_treq_valid;
  logic o_req_ready, o_fwd_valid, i_fwd_ready = 0, o_fwd_local;
  logic o_discard, o_scan_valid, i_scan_ready = 0, o_scan_port;
  logic o_scan_dir, i_gd_valid = 0, o_mbx_wr, go = 0, tcp = 0, prt = 0;
  logic busy;
  logic [1:0] o_fwd_src;
  logic [LEN_W-1:0] o_fwd_len, o_scan_len;
  logic [ROUTE_W-1:0] o_fwd_route, o_scan_route, rt, rt3;
  logic [7:0] o_fwd_ret_drop, o_scan_count;
  logic [11:0] o_scan_local, o_mbx_addr;
  logic [13:0] o_scan_remote;
  logic [5:0] i_gd_node = 0;
  logic [4:0] i_gd_word = 0;
  logic [15:0] i_gd_data = 0, o_mbx_data, lf = 16'h579b;
  logic [103:0] fq[$], gq[$], sx = 0;
  int error_cnt = 0, check_count = 0, sc = 0;
  always #4 i_clk = ~i_clk;
  mst_top i_dut (.i_clk, .i_sys_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
    .i_sreq_valid, .i_sreq_port, .i_sreq_addr, .i_treq_valid,
    .i_treq_index, .o_req_ready, .o_fwd_valid, .i_fwd_ready, .o_fwd_src,
    .o_fwd_local, .o_fwd_len, .o_fwd_route, .o_fwd_ret_drop, .o_discard,
    .o_scan_valid, .i_scan_ready, .o_scan_port, .o_scan_dir,
    .o_scan_local, .o_scan_remote, .o_scan_count, .o_scan_len,
    .o_scan_route, .i_gd_valid, .i_gd_node, .i_gd_word, .i_gd_data,
    .o_mbx_wr, .o_mbx_addr, .o_mbx_data);
  mst_req_model i_req (.i_clk, .i_go(go), .i_tcp(tcp), .i_port(prt),
    .i_addr(adr), .i_ready(o_req_ready), .o_busy(busy),
    .o_sreq_valid(i_sreq_valid), .o_sreq_port(i_sreq_port),
    .o_sreq_addr(i_sreq_addr), .o_treq_valid(i_treq_valid),
    .o_treq_index(i_treq_index));
  // ==========================================================
  // Shared tasks
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(logic [103:0] s, logic [103:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Avalon access held until waitrequest is sampled low
  task automatic av(logic w, logic [7:0] a, logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) begin
      chk(1, 0);
      finish_test();
    end
    r = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic rw(logic [8:0] ix, logic [3:0] ln, logic [63:0] v);
    logic [31:0] r;
    av(1, REG_STAGE_LO, v[31:0], r);
    av(1, REG_STAGE_HI, v[63:32], r);
    av(1, REG_ROUTE_WR, {12'h000, ln, 7'h00, ix}, r);
  endtask
  // Issue one request and wait for its result to be compared
  task automatic rq(logic t, logic p, logic [7:0] a, logic [79:0] e);
    int n;
    fq.push_back(e);
    @(posedge i_clk);
    go <= 1'b1;
    tcp <= t;
    prt <= p;
    adr <= a;
    @(posedge i_clk);
    go <= 1'b0;
    for (n = 0; n < 200 && fq.size() > 0; n++) @(posedge i_clk);
    if (n == 200) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // ==========================================================
  // Output monitor: oldest note against each result; random stalls
  always @(posedge i_clk) begin
    if (o_discard === 1'b1) chk(80'h1 << 79, fq.size() ? fq.pop_front()
      : '1);
    else if (o_fwd_valid === 1'b1 && i_fwd_ready === 1'b1)
      chk({1'b0, o_fwd_src, o_fwd_local, o_fwd_len, o_fwd_route,
        o_fwd_ret_drop}, fq.size() ? fq.pop_front() : '1);
    if (o_mbx_wr === 1'b1)
      chk({o_mbx_addr, o_mbx_data}, gq.size() ? gq.pop_front() : '1);
    if (o_scan_valid === 1'b1 && i_scan_ready === 1'b1) begin
      sc <= sc + 1;
      chk({o_scan_port, o_scan_dir, o_scan_local, o_scan_remote,
        o_scan_count, o_scan_len, o_scan_route}, sx);
    end
    i_fwd_ready <= lf[0];
    i_scan_ready <= lf[1];
    lf <= nx(lf);
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    localparam logic [79:0] D = 80'h1 << 79;
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    av(0, REG_START0, 0, r);
    chk(r, 32'h1);
    av(0, REG_CTRL, 0, r);
    chk(r, 0);
    av(0, 8'h3c, 0, r);
    chk(r, 0);
    av(1, REG_ETH_DROP, 32'h2a, r);
    av(1, REG_CTRL, 32'h3, r);
    av(1, REG_START1, 32'h81, r);
    rt = {lf, lf, lf, lf[7:0], 8'h65};
    rt3 = {40'h0, lf[7:0], 16'h0566};
    rw(9'h000, 4'h8, rt);
    rw(9'h07f, 4'h3, rt3);
    rw(9'h005, 4'h0, 64'h0);
    rw(9'h080, 4'h2, rt3);
    rw(9'h1ff, 4'h0, 64'h0);
    rw(9'h107, 4'h2, rt3);
    rq(0, 0, 8'h01, {1'b0, SRC_SER0, 1'b0, 4'h8, rt, rt[7:0]});
    rq(0, 0, 8'h80, {1'b0, SRC_SER0, 1'b0, 4'h3, rt3, 8'h66});
    rq(0, 0, 8'h81, D);
    rq(0, 0, 8'h00, D);
    rq(0, 0, 8'h06, D);
    rq(0, 1, 8'h81, {1'b0, SRC_SER1, 1'b0, 4'h2, rt3, 8'h66});
    rq(1, 0, 8'h07, {1'b0, SRC_ETH, 1'b0, 4'h2, rt3, 8'h2a});
    rq(1, 0, 8'hff, {1'b0, SRC_ETH, 1'b1, 4'h0, 64'h0, 8'h2a});
    av(1, REG_CTRL, 32'h1, r);
    rq(0, 1, 8'h81, D);
    av(0, REG_STATUS, 0, r);
    chk(r, 32'h0005_0004);
    // Scan table: all 96 entries count-zero, then one enabled at the limits
    av(1, REG_SCAN_A, 32'h2000_0800, r);
    av(1, REG_SCAN_B, 32'h0, r);
    for (int i = 0; i < 96; i++)
      av(1, REG_SCAN_WR, {23'h0, i >= 48, 2'h0, 6'(i % 48)}, r);
    av(1, REG_SCAN_B, 32'h0000_2180, r);
    av(1, REG_SCAN_WR, 32'h0000_012f, r);
    sx = {1'b1, 1'b1, 12'h800, 14'h2000, 8'h80, 4'h2, rt3};
    av(1, REG_CTRL, 32'h4, r);
    repeat (600) @(posedge i_clk);
    chk(sc >= 2, 1);
    // Global data: node 3, two words at the top of the mailbox
    av(1, REG_GD_CFG, {4'h0, 12'h7fe, 2'h0, 6'h2, 2'h0, 6'h3}, r);
    for (int w = 0; w < 3; w++) begin
      @(posedge i_clk);
      i_gd_valid <= 1'b1;
      i_gd_node <= 6'h3;
      i_gd_word <= 5'(w);
      i_gd_data <= lf;
      if (w < 2) gq.push_back({12'h7fe + 12'(w), lf});
    end
    @(posedge i_clk);
    i_gd_valid <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk(fq.size() + gq.size(), 0);
    finish_test();
  end
endmodule
